// ---- hdl/vid_pkg.sv ----
// Constants shared by the voltage-ID monitor and its supply code mapper.
// Assumes a 125 MHz core clock and a byte-wide register port from the
// SMBus serial engine.
package vid_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CHANGE_WINDOW_NS = 11000;
  localparam int unsigned CHANGE_WINDOW_CYC =
    CHANGE_WINDOW_NS / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h40;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_VOLTAGE_ID_CODE = 8'h43;
  localparam logic [7:0] ADDR_INT_MASK_TWO = 8'h75;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int unsigned BIT_PIN_SELECT = 7;
  localparam int unsigned BIT_THRESHOLD = 6;
  localparam int unsigned BIT_SIXTH_INPUT = 5;
  localparam int unsigned BIT_SHARED_FLAG = 0;
  localparam int unsigned BIT_CODE_CHANGE_MASK = 0;
  localparam int unsigned BIT_SUPPLY_5V = 7;

  localparam logic RESET_PIN_SELECT = 1'b0;
  localparam logic RESET_THRESHOLD = 1'b0;
  localparam logic RESET_MASK = 1'b0;
  localparam logic RESET_SUPPLY_5V = 1'b0;

  // Device address returned on an alert response; the value is arbitrary.
  localparam logic [6:0] DEFAULT_DEVICE_ADDR = 7'h2e;

  // Input voltages are in units of 0.1 mV.
  localparam int unsigned VIN_W = 18;
  localparam int unsigned CODE_W = 10;
  localparam logic [9:0] CODE_NOMINAL = 10'h300;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [27:0] NOM_2V5 = 28'd25000;
  localparam logic [27:0] NOM_VCCP = 28'd22500;
  localparam logic [27:0] NOM_3V3 = 28'd33000;
  localparam logic [27:0] NOM_5V = 28'd50000;
  localparam logic [27:0] NOM_12V = 28'd120000;

  typedef enum logic [2:0] {
    VID_CH_2V5,
    VID_CH_VCCP,
    VID_CH_VCC,
    VID_CH_5V,
    VID_CH_12V
  } vid_chan_t;
endpackage

// ---- hdl/vid_code_map.sv ----
// Maps a supply channel's input voltage onto its 10-bit converter code.
// Assumes the voltage arrives already digitised in 0.1 mV units.
`timescale 1ns/1ps
module vid_code_map
  import vid_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire vid_chan_t chan,
  input wire logic [VIN_W-1:0] vin,
  input wire logic supply_5v,
  output logic [CODE_W-1:0] code_q
);
  logic [27:0] nominal;
  logic [27:0] scaled;
  logic [27:0] ratio;
  logic [CODE_W-1:0] code_d;

  // Vcc nominal follows the supply option.
  assign nominal = (chan == VID_CH_2V5) ? NOM_2V5 :
                   (chan == VID_CH_VCCP) ? NOM_VCCP :
                   (chan == VID_CH_VCC) ? (supply_5v ? NOM_5V : NOM_3V3) :
                   (chan == VID_CH_5V) ? NOM_5V : NOM_12V;
  // nominal input lands on three-quarter scale.
  assign scaled = 28'(vin) * 28'(CODE_NOMINAL);
  assign ratio = scaled / nominal;
  // saturate above the top code; below one step truncates to 0.
  assign code_d = (ratio > 28'(CODE_MAX)) ? CODE_MAX : ratio[CODE_W-1:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      code_q <= '0;
    end else begin
      code_q <= code_d;
    end
  end

  // nominal 12 V maps to code 768.
  a_map_nominal: assert property (
    @(posedge clk) disable iff (reset)
    (chan == VID_CH_12V && vin == 18'd120000) |=> code_q == 10'h300)
    else $error("12 V nominal did not map to 768");
  a_map_clamp: assert property (
    @(posedge clk) disable iff (reset)
    (chan == VID_CH_12V && vin > 18'd160000) |=> code_q == 10'h3ff)
    else $error("overrange code not clamped");
endmodule

// ---- hdl/vid_monitor.sv ----
// Voltage-ID input monitor with shared pin select and code change detect.
// Assumes an SMBus engine outside that turns bus transfers into single
// cycle register reads and writes and reports alert response reads.
//
// Overview of operation
// - The pin select bit 7 of register 0x43 sets the shared pin to 12 V input (0) or sixth code input (1) and reads back.
// - With select 0, bit 5 of register 0x43 always reads 0.
// - With select 1, bit 5 of register 0x43 shows the shared pin level.
// - In 12 V mode bit 0 of register 0x42 shows the 12 V out-of-limit state.
// - In sixth-input mode bit 0 of register 0x42 shows a code change.
// - In sixth-input mode the 12 V measurement on the pin is stopped.
// - The change flag sets when the code differs from the snapshot taken at each 11 us interval end and holds until a 0x42 status read or 12 V mode clears it.
// - Change detection runs only in sixth-input mode.
// - An unmasked code change pulls the alert output low.
// - Mask bit 0 of register 0x75 blocks the alert but not the flag.
// - Each supply channel gives a 10-bit code with 768 at nominal.
// - Vcc codes assume 3.3 V unless the 5 V option bit is set.
// - While alerting, the device answers the alert response address.
`timescale 1ns/1ps
module vid_monitor
  import vid_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = DEFAULT_DEVICE_ADDR
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] vid_pins,
  input wire logic shared_pin,
  input wire logic v12_out_of_limit,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic ara_read,
  output logic ara_respond,
  output logic [6:0] ara_address,
  output logic smbalert_o,
  output logic smbalert_oe_n,
  output logic v12_measure_en,
  output logic vid_threshold_low,
  input wire vid_chan_t meas_chan,
  input wire logic [VIN_W-1:0] meas_vin,
  output logic [CODE_W-1:0] meas_code_q
);
  localparam logic [10:0] WINDOW_LAST = 11'(CHANGE_WINDOW_CYC - 1);

  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic pin_function_select_q;
  logic threshold_q;
  logic mask_q;
  logic supply_5v_q;
  logic [10:0] window_q;
  logic [10:0] window_d;
  logic [5:0] snapshot_q;
  logic change_flag_q;
  logic change_flag_d;
  logic [5:0] voltage_identification;
  logic window_end;
  logic code_differs;
  logic shared_flag;
  logic alert;
  logic wr_vid;
  logic wr_mask;
  logic wr_cfg;
  logic rd_status;
  logic [7:0] rdata_d;

  // Both flops feed only the second stage or the logic after it.
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {shared_pin, vid_pins};
      sync2_q <= sync1_q;
    end
  end

  // sixth input forced to 0 in 12 V mode.
  // otherwise it follows the synchronised pin.
  assign voltage_identification =
    {sync2_q[5] & pin_function_select_q, sync2_q[4:0]};

  assign wr_vid = reg_wr && reg_addr == ADDR_VOLTAGE_ID_CODE;
  assign wr_mask = reg_wr && reg_addr == ADDR_INT_MASK_TWO;
  assign wr_cfg = reg_wr && reg_addr == ADDR_CONFIG_ONE;
  assign rd_status = reg_rd && reg_addr == ADDR_STATUS_TWO;

  // select bit stored from software writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_function_select_q <= RESET_PIN_SELECT;
      threshold_q <= RESET_THRESHOLD;
      mask_q <= RESET_MASK;
      supply_5v_q <= RESET_SUPPLY_5V;
    end else begin
      if (wr_vid) begin
        pin_function_select_q <= reg_wdata[BIT_PIN_SELECT];
        threshold_q <= reg_wdata[BIT_THRESHOLD];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[BIT_CODE_CHANGE_MASK];
      end
      if (wr_cfg) begin
        supply_5v_q <= reg_wdata[BIT_SUPPLY_5V];
      end
    end
  end

  // 11 us interval timer with snapshot at each end.
  assign window_end = window_q == WINDOW_LAST;
  assign window_d = window_end ? '0 : window_q + 11'd1;
  assign code_differs = voltage_identification != snapshot_q;

  // set on difference; a status read clears, but set wins.
  assign change_flag_d = !pin_function_select_q ? 1'b0 :
                         code_differs ? 1'b1 :
                         rd_status ? 1'b0 : change_flag_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      window_q <= '0;
      snapshot_q <= '0;
      change_flag_q <= 1'b0;
    end else begin
      window_q <= window_d;
      if (window_end) begin
        snapshot_q <= voltage_identification;
      end
      change_flag_q <= change_flag_d;
    end
  end

  // 12 V limit state in 12 V mode.
  assign shared_flag = pin_function_select_q ? change_flag_q
                                             : v12_out_of_limit;
  // mask gates the output only, not the flag.
  assign alert = shared_flag & ~mask_q;
  assign smbalert_o = 1'b0;
  assign smbalert_oe_n = ~alert;
  // answer the alert response read while alerting.
  assign ara_respond = ara_read & alert;
  assign ara_address = DEVICE_ADDR;
  // 12 V conversion disabled once the pin is a code input.
  assign v12_measure_en = ~pin_function_select_q;
  assign vid_threshold_low = threshold_q;

  assign rdata_d =
    (reg_addr == ADDR_VOLTAGE_ID_CODE) ?
      {pin_function_select_q, threshold_q, voltage_identification} :
    (reg_addr == ADDR_STATUS_TWO) ? {7'h00, shared_flag} :
    (reg_addr == ADDR_INT_MASK_TWO) ? {7'h00, mask_q} :
    (reg_addr == ADDR_CONFIG_ONE) ? {supply_5v_q, 7'h00} : READ_UNMAPPED;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  vid_code_map u_map (
    .clk(clk),
    .reset(reset),
    .chan(meas_chan),
    .vin(meas_vin),
    .supply_5v(supply_5v_q),
    .code_q(meas_code_q)
  );

  // Cycles since the last snapshot, counted apart from the timer; a plain
  // delay over a whole interval would be far too long for the checker.
  logic [10:0] gap_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= '0;
    end else if (window_end) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 11'd1;
    end
  end

  a_sel_readback: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h43) |=>
    reg_rdata_q[7] == $past(pin_function_select_q))
    else $error("select bit readback wrong");
  a_sixth_zero: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h43 && !pin_function_select_q) |=>
    !reg_rdata_q[5])
    else $error("sixth input bit not zero in 12 V mode");
  a_sixth_level: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h43 && pin_function_select_q) |=>
    reg_rdata_q[5] == $past(sync2_q[5]))
    else $error("sixth input bit does not follow pin");
  a_limit_flag: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h42 && !pin_function_select_q) |=>
    reg_rdata_q[0] == $past(v12_out_of_limit))
    else $error("12 V limit flag not reported");
  a_change_flag: assert property (
    @(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 8'h42 && pin_function_select_q) |=>
    reg_rdata_q[0] == $past(change_flag_q))
    else $error("code change flag not reported");
  a_measure_off: assert property (
    @(posedge clk) disable iff (reset)
    pin_function_select_q |-> !v12_measure_en)
    else $error("12 V measured in code input mode");
  a_change_sets: assert property (
    @(posedge clk) disable iff (reset)
    (pin_function_select_q && voltage_identification != snapshot_q) |=>
    change_flag_q || !pin_function_select_q)
    else $error("code change not flagged");
  a_detect_off: assert property (
    @(posedge clk) disable iff (reset)
    !$past(pin_function_select_q) |-> !change_flag_q)
    else $error("change flag set in 12 V mode");
  a_alert_drive: assert property (
    @(posedge clk) disable iff (reset)
    (pin_function_select_q && change_flag_q && !mask_q) |->
    !smbalert_oe_n)
    else $error("unmasked change did not alert");
  a_alert_mask: assert property (
    @(posedge clk) disable iff (reset)
    mask_q |-> smbalert_oe_n)
    else $error("masked source raised alert");
  a_ara_answer: assert property (
    @(posedge clk) disable iff (reset)
    (ara_read && !smbalert_oe_n) |-> ara_respond)
    else $error("alert response not answered");
  a_window_len: assert property (
    @(posedge clk) disable iff (reset)
    window_end |-> gap_q == WINDOW_LAST)
    else $error("snapshot interval too short");
  a_window_due: assert property (
    @(posedge clk) disable iff (reset)
    gap_q <= WINDOW_LAST)
    else $error("snapshot interval too long");

  c_code_change: cover property (@(posedge clk) disable iff (reset)
    pin_function_select_q && code_differs ##1 change_flag_q);
  c_alert_ara: cover property (@(posedge clk) disable iff (reset)
    ara_respond);
  c_status_clear: cover property (@(posedge clk) disable iff (reset)
    change_flag_q && rd_status && !code_differs ##1 !change_flag_q);
endmodule

// ---- testbench/vid_proc_model.sv ----
// Behavioural model of the processor driving the voltage-ID lines.
// Assumes the bench asks for a six-bit code; bit 5 lands on the shared pin.
`timescale 1ns/1ps
module vid_proc_model #(
  parameter int SETTLE = 4
)
(
  input wire logic clk,
  input wire logic [5:0] code_req,
  output logic [4:0] vid_pins,
  output logic shared_pin
);
  // A slow regulator handover is mimicked by letting a new code settle
  // over several cycles; a SETTLE of 1 gives a prompt answer.
  logic [5:0] dly_q [0:SETTLE-1];
  always_ff @(posedge clk) begin
    dly_q[0] <= code_req;
    for (int i = 1; i < SETTLE; i++) begin
      dly_q[i] <= dly_q[i-1];
    end
  end
  assign vid_pins = dly_q[SETTLE-1][4:0];
  assign shared_pin = dly_q[SETTLE-1][5];
endmodule

// ---- testbench/voltage_id_pin_select_change_detect_tb_top.sv ----
// Self-checking bench for the voltage-ID monitor and its code mapper.
// Assumes the byte register port of the monitor and the processor model.
`timescale 1ns/1ps
module voltage_id_pin_select_change_detect_tb_top;
  import vid_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] code_req = 6'h35;
  logic [4:0] vid_pins;
  logic shared_pin;
  logic v12_out_of_limit = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic ara_read = 1'b0;
  logic ara_respond;
  logic [6:0] ara_address;
  logic smbalert_o;
  logic smbalert_oe_n;
  logic v12_measure_en;
  logic vid_threshold_low;
  vid_chan_t meas_chan = VID_CH_12V;
  logic [VIN_W-1:0] meas_vin = '0;
  logic [CODE_W-1:0] meas_code_q;
  int mismatches = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  vid_proc_model #(.SETTLE(4)) i_vid_proc_model (.clk(clk),
    .code_req(code_req), .vid_pins(vid_pins), .shared_pin(shared_pin));

  vid_monitor i_vid_monitor (.clk(clk), .reset(reset), .vid_pins(vid_pins),
    .shared_pin(shared_pin), .v12_out_of_limit(v12_out_of_limit),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .ara_read(ara_read),
    .ara_respond(ara_respond), .ara_address(ara_address),
    .smbalert_o(smbalert_o), .smbalert_oe_n(smbalert_oe_n),
    .v12_measure_en(v12_measure_en), .vid_threshold_low(vid_threshold_low),
    .meas_chan(meas_chan), .meas_vin(meas_vin), .meas_code_q(meas_code_q));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Status reads of 0x42 also clear the change flag, so some reads are made only for that.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(reg_rdata_q, exp);
  endtask

  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    while (smbalert_oe_n !== lvl && n < 16) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(smbalert_oe_n, lvl);
  endtask

  task automatic map_check(input vid_chan_t ch, input logic [17:0] v,
                           input logic [9:0] exp);
    @(posedge clk);
    meas_chan <= ch;
    meas_vin <= v;
    repeat (2) @(posedge clk);
    #1;
    check(meas_code_q, exp);
  endtask

  // The whole run needs a few thousand cycles; this bound is 50,000.
  initial begin
    #400_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(v12_measure_en, 1'b1);
    reg_read(ADDR_VOLTAGE_ID_CODE, 8'h15);
    reg_read(8'h10, READ_UNMAPPED);
    @(posedge clk) v12_out_of_limit <= 1'b1;
    wait_alert(1'b0);
    reg_read(ADDR_STATUS_TWO, 8'h01);
    reg_write(ADDR_INT_MASK_TWO, 8'h01);
    wait_alert(1'b1);
    reg_read(ADDR_INT_MASK_TWO, 8'h01);
    reg_write(ADDR_VOLTAGE_ID_CODE, 8'hc0);
    reg_read(ADDR_VOLTAGE_ID_CODE, 8'hf5);
    check(vid_threshold_low, 1'b1);
    check(v12_measure_en, 1'b0);
    repeat (CHANGE_WINDOW_CYC + 20) @(posedge clk);
    rd(ADDR_STATUS_TWO);
    reg_read(ADDR_STATUS_TWO, 8'h00);
    @(posedge clk) code_req <= 6'h2a;
    repeat (12) @(posedge clk);
    #1;
    check(smbalert_oe_n, 1'b1);
    reg_write(ADDR_INT_MASK_TWO, 8'h00);
    wait_alert(1'b0);
    check(smbalert_o, 1'b0);
    @(posedge clk) ara_read <= 1'b1;
    @(posedge clk) #1;
    check(ara_respond, 1'b1);
    check(ara_address, DEFAULT_DEVICE_ADDR);
    @(posedge clk) ara_read <= 1'b0;
    reg_read(ADDR_STATUS_TWO, 8'h01);
    repeat (CHANGE_WINDOW_CYC + 20) @(posedge clk);
    rd(ADDR_STATUS_TWO);
    reg_read(ADDR_STATUS_TWO, 8'h00);
    wait_alert(1'b1);
    reg_write(ADDR_VOLTAGE_ID_CODE, 8'h00);
    @(posedge clk) v12_out_of_limit <= 1'b0;
    code_req <= 6'h35;
    repeat (12) @(posedge clk);
    reg_read(ADDR_STATUS_TWO, 8'h00);
    reg_read(ADDR_VOLTAGE_ID_CODE, 8'h15);
    check(v12_measure_en, 1'b1);
    map_check(VID_CH_12V, 18'd120000, 10'd768);
    map_check(VID_CH_12V, 18'd157, 10'd1);
    map_check(VID_CH_12V, 18'd100, 10'd0);
    map_check(VID_CH_12V, 18'd250000, 10'd1023);
    map_check(VID_CH_2V5, 18'd12500, 10'd384);
    map_check(VID_CH_VCCP, 18'd22500, 10'd768);
    map_check(VID_CH_5V, 18'd40000, 10'd614);
    map_check(VID_CH_VCC, 18'd33000, 10'd768);
    reg_write(ADDR_CONFIG_ONE, 8'h80);
    reg_read(ADDR_CONFIG_ONE, 8'h80);
    map_check(VID_CH_VCC, 18'd50000, 10'd768);
    give_verdict();
  end
endmodule
